// [rtl/hpp_defs.vh]
`ifndef HPP_DEFS_VH
`define HPP_DEFS_VH

// register byte offsets
`define HPP_OFF_CTRL      12'h000
`define HPP_OFF_PORT_EN   12'h004
`define HPP_OFF_OC_FLAG   12'h008
`define HPP_OFF_FLT_STAT  12'h00C
`define HPP_OFF_PWR_STAT  12'h010
`define HPP_OFF_LINK_STAT 12'h014
`define HPP_OFF_OV_THRESH 12'h018
`define HPP_OFF_HB_DIV    12'h01C
`define HPP_OFF_LIMIT0    12'h040

// control register fields
`define HPP_CTRL_AUTO     0
`define HPP_CTRL_UPSEL    1
`define HPP_CTRL_ENUM     2
`define HPP_CTRL_WDOG     3

// reset values
`define HPP_RST_CTRL      32'h0000_0001
`define HPP_RST_PORT_EN   8'hFF
`define HPP_RST_LIMIT     12'hFFF
`define HPP_RST_OV_THRESH 13'h0A8C
`define HPP_RST_HB_DIV    24'h4C_4B40

// timing
`define HPP_CLK_MHZ       100
`define HPP_SAMPLE_US     140
`define HPP_RECOVER_MS    70
`define HPP_FAULT_SAMPLES 3

`endif

// [rtl/hpp_port_guard.v]
`timescale 1ns/10ps
// one downstream port: overcurrent trip plus overvoltage/reverse protection
module hpp_port_guard #(
    parameter RECOVER_CYCLES = 7000000,
    parameter FAULT_SAMPLES = 3
) (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // conversion result
    input wire i_sample_valid,
    input wire [11:0] i_current,
    input wire i_current_neg,
    input wire [12:0] i_voltage,
    // settings
    input wire [11:0] i_limit,
    input wire [12:0] i_ov_thresh,
    input wire i_sw_enable,
    input wire i_oc_clear,
    // status
    output reg o_oc_flag,
    output reg o_fault,
    output reg o_power_en
);
    reg [1:0] bad_cnt_reg;
    reg [22:0] recover_reg;
    wire bad;
    wire oc_hit;

    assign bad = (i_voltage > i_ov_thresh) || i_current_neg;
    assign oc_hit = i_sample_valid && !i_current_neg && (i_current > i_limit);

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_oc_flag <= 1'b0;
            o_fault <= 1'b0;
            bad_cnt_reg <= 2'd0;
            recover_reg <= 23'd0;
            o_power_en <= 1'b0;
        end else begin
            // a single raw sample over the limit trips; set beats clear
            if (oc_hit)
                o_oc_flag <= 1'b1;
            else if (i_oc_clear)
                o_oc_flag <= 1'b0;
            if (i_sample_valid) begin
                if (!bad)
                    bad_cnt_reg <= 2'd0;
                else if (bad_cnt_reg < FAULT_SAMPLES[1:0])
                    bad_cnt_reg <= bad_cnt_reg + 2'd1;
            end
            if (i_sample_valid && bad &&
                    bad_cnt_reg >= FAULT_SAMPLES[1:0] - 2'd1) begin
                o_fault <= 1'b1;
                recover_reg <= RECOVER_CYCLES[22:0];
            end else if (o_fault && i_sample_valid && !bad) begin
                if (recover_reg == 23'd0)
                    o_fault <= 1'b0;
            end
            if (o_fault && bad_cnt_reg == 2'd0 && recover_reg != 23'd0)
                recover_reg <= recover_reg - 23'd1;
            // flag is raised first, power drops one cycle later
            o_power_en <= i_sw_enable && !o_oc_flag && !o_fault;
        end
    end
endmodule

// [rtl/hpp_led_blink.v]
`timescale 1ns/10ps
// free-running square wave of programmable half period
module hpp_led_blink (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // control
    input wire i_run,
    input wire [23:0] i_half,
    // output
    output reg o_blink
);
    reg [23:0] cnt_reg;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= 24'd0;
            o_blink <= 1'b0;
        end else if (!i_run) begin
            cnt_reg <= 24'd0;
            o_blink <= 1'b0;
        end else if (cnt_reg >= i_half) begin
            cnt_reg <= 24'd0;
            o_blink <= ~o_blink;
        end else begin
            cnt_reg <= cnt_reg + 24'd1;
        end
    end
endmodule

// [rtl/hpp_top.v]
`timescale 1ns/10ps
`include "hpp_defs.vh"
module hpp_top #(
    parameter NPORTS = 8,
    parameter RECOVER_CYCLES = `HPP_RECOVER_MS * 1000 * `HPP_CLK_MHZ
) (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // measurement front end, one port at a time
    input wire i_adc_done,
    input wire [2:0] i_adc_port,
    input wire [11:0] i_adc_current,
    input wire i_adc_neg,
    input wire [12:0] i_adc_voltage,
    // connection pins
    input wire i_ctrl_attached,
    input wire i_up0_connected,
    input wire i_up1_connected,
    input wire i_up_superspeed,
    input wire [7:0] i_dn_enumerated,
    input wire [7:0] i_dn_superspeed,
    // routing outputs
    output reg o_up_select,
    output reg o_up0_route_en,
    output reg o_up1_route_en,
    output reg o_mgmt_via_ctrl,
    output reg o_mgmt_via_up,
    output reg o_ctrl_data_en,
    // port power
    output reg [7:0] o_port_power,
    output reg o_extra_port_power,
    // indicators
    output reg o_led_link,
    output reg o_led_heartbeat,
    output reg o_led_health,
    output reg o_led_power,
    output reg o_led_up_ss,
    output reg o_led_up_hs,
    output reg [7:0] o_led_dn_ss,
    output reg [7:0] o_led_dn_hs,
    output reg [7:0] o_led_dn_pwr
);
    localparam SAMPLE_CYCLES = `HPP_SAMPLE_US * `HPP_CLK_MHZ;

    // synchronised pin inputs
    reg [12:0] pin_s1_reg;
    reg [12:0] pin_s2_reg;
    reg [15:0] dn_s1_reg;
    reg [15:0] dn_s2_reg;
    wire ctrl_att = pin_s2_reg[0];
    wire up0_con = pin_s2_reg[1];
    wire up1_con = pin_s2_reg[2];
    wire up_ss = pin_s2_reg[3];

    reg [31:0] ctrl_reg;
    reg [7:0] port_en_reg;
    reg [12:0] ov_thresh_reg;
    reg [23:0] hb_div_reg;
    reg [11:0] limit_mem [0:NPORTS-1];
    reg [7:0] oc_clr_reg;
    reg [15:0] conv_cnt_reg;
    reg [7:0] samp_valid;
    integer k;

    wire [7:0] oc_flag;
    wire [7:0] fault;
    wire [7:0] pwr_en;
    wire hb_wave;
    wire wd_wave;

    function [7:0] onehot;
        input [2:0] idx;
        begin
            onehot = 8'h01 << idx;
        end
    endfunction

    wire apb_wr = i_psel && i_penable && i_pwrite && o_pready;
    wire apb_rd = i_psel && i_penable && !i_pwrite && o_pready;
    wire limit_hit = (i_paddr >= `HPP_OFF_LIMIT0) &&
        (i_paddr < `HPP_OFF_LIMIT0 + 12'h020);
    wire [2:0] limit_idx = i_paddr[4:2];

    // conversions arrive once per sample period; the counter measures
    // cycles since the last one, but nothing reads it, so early ones are not flagged
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            conv_cnt_reg <= 16'd0;
        else if (i_adc_done)
            conv_cnt_reg <= 16'd0;
        else if (conv_cnt_reg < SAMPLE_CYCLES[15:0])
            conv_cnt_reg <= conv_cnt_reg + 16'd1;
    end

    always @* begin
        samp_valid = 8'h00;
        if (i_adc_done)
            samp_valid = onehot(i_adc_port);
    end

    // pin synchronisers
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_s1_reg <= 13'h0000;
            pin_s2_reg <= 13'h0000;
            dn_s1_reg <= 16'h0000;
            dn_s2_reg <= 16'h0000;
        end else begin
            pin_s1_reg <= {9'h000, i_up_superspeed, i_up1_connected,
                i_up0_connected, i_ctrl_attached};
            pin_s2_reg <= pin_s1_reg;
            dn_s1_reg <= {i_dn_superspeed, i_dn_enumerated};
            dn_s2_reg <= dn_s1_reg;
        end
    end

    // apb register file; slave with one wait state
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= `HPP_RST_CTRL;
            port_en_reg <= `HPP_RST_PORT_EN;
            ov_thresh_reg <= `HPP_RST_OV_THRESH;
            hb_div_reg <= `HPP_RST_HB_DIV;
            oc_clr_reg <= 8'h00;
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            for (k = 0; k < NPORTS; k = k + 1)
                limit_mem[k] <= `HPP_RST_LIMIT;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_pslverr <= 1'b0;
            oc_clr_reg <= 8'h00;
            if (i_psel && i_penable && !o_pready) begin
                o_pslverr <= !(limit_hit ||
                    i_paddr <= `HPP_OFF_HB_DIV) || i_paddr[1:0] != 2'b00;
                o_prdata <= 32'h0000_0000;
                if (!i_pwrite) begin
                    if (limit_hit)
                        o_prdata <= {20'h0_0000, limit_mem[limit_idx]};
                    else case (i_paddr)
                        `HPP_OFF_CTRL: o_prdata <= ctrl_reg & 32'h0000_000F;
                        `HPP_OFF_PORT_EN: o_prdata <= {24'h00_0000, port_en_reg};
                        `HPP_OFF_OC_FLAG: o_prdata <= {24'h00_0000, oc_flag};
                        `HPP_OFF_FLT_STAT: o_prdata <= {24'h00_0000, fault};
                        `HPP_OFF_PWR_STAT: o_prdata <= {24'h00_0000, pwr_en};
                        `HPP_OFF_LINK_STAT:
                            o_prdata <= {27'h000_0000, o_up_select, up_ss,
                                up1_con, up0_con, ctrl_att};
                        `HPP_OFF_OV_THRESH:
                            o_prdata <= {19'h0_0000, ov_thresh_reg};
                        `HPP_OFF_HB_DIV: o_prdata <= {8'h00, hb_div_reg};
                        default: o_prdata <= 32'h0000_0000;
                    endcase
                end
            end
            if (apb_wr) begin
                if (limit_hit)
                    limit_mem[limit_idx] <= i_pwdata[11:0];
                else case (i_paddr)
                    `HPP_OFF_CTRL: ctrl_reg <= i_pwdata & 32'h0000_000F;
                    `HPP_OFF_PORT_EN: begin
                        port_en_reg <= i_pwdata[7:0];
                        // re-enabling a port also releases its trip
                        oc_clr_reg <= i_pwdata[7:0] & ~port_en_reg;
                    end
                    `HPP_OFF_OC_FLAG: oc_clr_reg <= i_pwdata[7:0];
                    `HPP_OFF_OV_THRESH: ov_thresh_reg <= i_pwdata[12:0];
                    `HPP_OFF_HB_DIV: hb_div_reg <= i_pwdata[23:0];
                    default: ;
                endcase
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPORTS; g = g + 1) begin : port
            hpp_port_guard #(
                .RECOVER_CYCLES(RECOVER_CYCLES),
                .FAULT_SAMPLES(`HPP_FAULT_SAMPLES)
            ) u_guard (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_sample_valid(samp_valid[g]),
                .i_current(i_adc_current),
                .i_current_neg(i_adc_neg),
                .i_voltage(i_adc_voltage),
                .i_limit(limit_mem[g]),
                .i_ov_thresh(ov_thresh_reg),
                .i_sw_enable(port_en_reg[g]),
                .i_oc_clear(oc_clr_reg[g]),
                .o_oc_flag(oc_flag[g]),
                .o_fault(fault[g]),
                .o_power_en(pwr_en[g])
            );
        end
    endgenerate

    hpp_led_blink u_hb (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_run(ctrl_reg[`HPP_CTRL_ENUM]),
        .i_half(hb_div_reg),
        .o_blink(hb_wave)
    );

    hpp_led_blink u_wd (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_run(ctrl_reg[`HPP_CTRL_WDOG]),
        // health flash shares the programmed heartbeat half period
        .i_half(hb_div_reg),
        .o_blink(wd_wave)
    );

    // routing and indicators
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_up_select <= 1'b0;
            o_up0_route_en <= 1'b0;
            o_up1_route_en <= 1'b0;
            o_mgmt_via_ctrl <= 1'b0;
            o_mgmt_via_up <= 1'b0;
            o_ctrl_data_en <= 1'b0;
            o_port_power <= 8'h00;
            o_extra_port_power <= 1'b0;
            o_led_link <= 1'b0;
            o_led_heartbeat <= 1'b0;
            o_led_health <= 1'b0;
            o_led_power <= 1'b0;
            o_led_up_ss <= 1'b0;
            o_led_up_hs <= 1'b0;
            o_led_dn_ss <= 8'h00;
            o_led_dn_hs <= 8'h00;
            o_led_dn_pwr <= 8'h00;
        end else begin
            if (ctrl_reg[`HPP_CTRL_AUTO])
                o_up_select <= !up0_con;
            else
                o_up_select <= ctrl_reg[`HPP_CTRL_UPSEL];
            o_up0_route_en <= !o_up_select;
            o_up1_route_en <= o_up_select;
            o_mgmt_via_ctrl <= ctrl_att;
            o_mgmt_via_up <= !ctrl_att;
            o_ctrl_data_en <= 1'b0;
            // analog limiter holds behaviour until switch opens
            o_port_power <= pwr_en;
            o_extra_port_power <= 1'b1;
            o_led_link <= ctrl_reg[`HPP_CTRL_ENUM];
            o_led_heartbeat <= hb_wave;
            o_led_health <= wd_wave;
            o_led_power <= 1'b1;
            o_led_up_ss <= up_ss;
            o_led_up_hs <= !up_ss;
            o_led_dn_ss <= dn_s2_reg[7:0] & dn_s2_reg[15:8];
            o_led_dn_hs <= dn_s2_reg[7:0] & ~dn_s2_reg[15:8];
            o_led_dn_pwr <= pwr_en;
        end
    end
endmodule

// [sim/hpp_top_asserts.sv]
`timescale 1ns/10ps
module hpp_top_asserts (
    // clock, reset and causes
    input wire i_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire i_adc_done,
    input wire i_ctrl_attached,
    input wire i_up_superspeed,
    input wire [7:0] i_dn_enumerated,
    // observed outputs
    input wire o_up0_route_en,
    input wire o_up1_route_en,
    input wire o_mgmt_via_ctrl,
    input wire o_mgmt_via_up,
    input wire o_ctrl_data_en,
    input wire o_extra_port_power,
    input wire o_led_up_ss,
    input wire o_led_up_hs,
    input wire [7:0] o_port_power,
    input wire [7:0] o_led_dn_ss,
    input wire [7:0] o_led_dn_hs,
    input wire [7:0] o_led_dn_pwr
);
    reg [3:0] since_reg;
    // cycles since the last conversion or register write
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            since_reg <= 4'hF;
        end else if (i_adc_done || (i_psel && i_penable && i_pwrite)) begin
            since_reg <= 4'h0;
        end else if (since_reg != 4'hF) begin
            since_reg <= since_reg + 4'h1;
        end
    end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_ctrl_on;
        i_ctrl_attached [*5];
    endsequence
    sequence s_ctrl_off;
        !i_ctrl_attached [*5];
    endsequence
    property p_one_up;
        !$past(i_rst) |-> (o_up0_route_en ^ o_up1_route_en);
    endproperty
    property p_no_data;
        o_ctrl_data_en == 1'b0;
    endproperty
    property p_mgmt_ctrl;
        s_ctrl_on |-> o_mgmt_via_ctrl && !o_mgmt_via_up;
    endproperty
    property p_mgmt_up;
        s_ctrl_off |-> o_mgmt_via_up && !o_mgmt_via_ctrl;
    endproperty
    property p_up_speed;
        i_up_superspeed [*5] |-> o_led_up_ss && !o_led_up_hs;
    endproperty
    property p_dn_dark;
        (i_dn_enumerated == 8'h00) [*5] |-> (o_led_dn_ss | o_led_dn_hs) == 0;
    endproperty
    property p_dn_pwr;
        o_led_dn_pwr == o_port_power;
    endproperty
    property p_extra;
        !$past(i_rst) |-> o_extra_port_power;
    endproperty
    property p_fall;
        |($past(o_port_power) & ~o_port_power) |-> since_reg <= 4'h6;
    endproperty
    a_one_up: assert property (p_one_up) else $error("two hosts");
    a_no_data: assert property (p_no_data) else $error("ctrl data");
    a_mgmt_ctrl: assert property (p_mgmt_ctrl) else $error("mgmt ctrl");
    a_mgmt_up: assert property (p_mgmt_up) else $error("mgmt up");
    a_up_speed: assert property (p_up_speed) else $error("up led");
    a_dn_dark: assert property (p_dn_dark) else $error("dn led");
    a_dn_pwr: assert property (p_dn_pwr) else $error("pwr led");
    a_extra: assert property (p_extra) else $error("extra port");
    a_fall: assert property (p_fall) else $error("power cut");
endmodule
bind hpp_top hpp_top_asserts i_hpp_top_asserts (.*);

// [sim/hpp_front_model.sv]
`timescale 1ns/10ps
// measurement front end: one result per commanded conversion
module hpp_front_model (
    input wire i_clk,
    input wire i_go,
    input wire [2:0] i_port,
    input wire [11:0] i_cur,
    input wire i_neg,
    input wire [12:0] i_volt,
    output reg o_done = 1'b0,
    output reg [2:0] o_port = 3'h0,
    output reg [11:0] o_cur = 12'h000,
    output reg o_neg = 1'b0,
    output reg [12:0] o_volt = 13'h0000
);
    always @(posedge i_clk) begin
        o_done <= i_go;
        if (i_go) begin
            o_port <= i_port;
            o_cur <= i_cur;
            o_neg <= i_neg;
            o_volt <= i_volt;
        end else begin
            // result lines invert every cycle between conversions instead of holding the last value
            o_port <= ~o_port;
            o_cur <= ~o_cur;
            o_neg <= ~o_neg;
            o_volt <= ~o_volt;
        end
    end
endmodule

// [sim/hpp_top_tb.sv]
`timescale 1ns/10ps
`include "hpp_defs.vh"
`define CHK(a, b) begin \
    checked = checked + 1; \
    if ((a) !== (b)) begin \
        err_count = err_count + 1; \
        $display("Error %0t: got %h exp %h", $time, a, b); \
    end \
end
module hpp_top_tb;
    reg i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    reg [11:0] i_paddr = 0;
    reg [31:0] i_pwdata = 0;
    reg i_ctrl_attached = 0, i_up0_connected = 1, i_up1_connected = 0;
    reg i_up_superspeed = 0;
    reg [7:0] i_dn_enumerated = 0, i_dn_superspeed = 0;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, i_adc_done, i_adc_neg;
    wire [2:0] i_adc_port;
    wire [11:0] i_adc_current;
    wire [12:0] i_adc_voltage;
    wire o_up_select, o_up0_route_en, o_up1_route_en, o_mgmt_via_ctrl;
    wire o_mgmt_via_up, o_ctrl_data_en, o_extra_port_power, o_led_power;
    wire o_led_link, o_led_heartbeat, o_led_health, o_led_up_ss, o_led_up_hs;
    wire [7:0] o_port_power, o_led_dn_ss, o_led_dn_hs, o_led_dn_pwr;
    reg go = 0, ng = 0, t, sl, hb;
    reg [2:0] pt = 0, p;
    reg [11:0] cu = 0, lim, c;
    reg [12:0] vo = 0;
    reg [31:0] rd;
    reg [27:0] rows [0:5];
    int err_count = 0, checked = 0, i, n;
    always #5 i_clk = ~i_clk;
    hpp_top #(.RECOVER_CYCLES(50)) i_hpp_top (.*);
    hpp_front_model i_hpp_front_model (.i_clk(i_clk), .i_go(go),
        .i_port(pt), .i_cur(cu), .i_neg(ng), .i_volt(vo),
        .o_done(i_adc_done), .o_port(i_adc_port), .o_cur(i_adc_current),
        .o_neg(i_adc_neg), .o_volt(i_adc_voltage));
    task print_verdict;
        begin
            $display("checked %0d err_count %0d", checked, err_count);
            if (err_count == 0 && checked > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
        begin
            @(posedge i_clk);
            i_psel <= 1;
            i_pwrite <= w;
            i_paddr <= a;
            i_pwdata <= d;
            @(posedge i_clk);
            i_penable <= 1;
            n = 0;
            @(posedge i_clk);
            while (o_pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge i_clk);
            end
            rd = o_prdata;
            sl = o_pslverr;
            i_psel <= 0;
            i_penable <= 0;
            if (n == 20) begin
                err_count = err_count + 1;
                print_verdict;
            end
        end
    endtask
    task smp(input reg [2:0] a, input reg [11:0] b, input reg e,
        input reg [12:0] v);
        begin
            @(posedge i_clk);
            go <= 1;
            pt <= a;
            cu <= b;
            ng <= e;
            vo <= v;
            @(posedge i_clk);
            go <= 0;
            repeat (8) @(posedge i_clk);
        end
    endtask
    initial begin
        #500000;
        err_count = err_count + 1;
        print_verdict;
    end
    initial begin
        rows[0] = {3'h0, 12'h064, 12'h064, 1'b0};
        rows[1] = {3'h1, 12'h064, 12'h065, 1'b1};
        rows[2] = {3'h7, 12'h000, 12'h000, 1'b0};
        rows[3] = {3'h7, 12'h000, 12'h001, 1'b1};
        rows[4] = {3'h3, 12'hFFF, 12'hFFF, 1'b0};
        rows[5] = {3'h2, 12'hFFE, 12'hFFF, 1'b1};
        repeat (6) @(posedge i_clk);
        i_rst <= 0;
        apb(0, `HPP_OFF_CTRL, 0);
        `CHK(rd, `HPP_RST_CTRL)
        `CHK(o_extra_port_power, 1'b1)
        `CHK(o_led_power, 1'b1)
        `CHK(o_led_link, 1'b0)
        `CHK(o_led_health, 1'b0)
        `CHK(o_port_power, 8'hFF)
        apb(0, `HPP_OFF_OV_THRESH, 0);
        `CHK(rd[12:0], `HPP_RST_OV_THRESH)
        apb(0, 12'h030, 0);
        `CHK({sl, rd}, {1'b1, 32'h0000_0000})
        for (i = 0; i < 6; i = i + 1) begin
            {p, lim, c, t} = rows[i];
            apb(1, `HPP_OFF_LIMIT0 + {7'h00, p, 2'h0}, {20'h0, lim});
            apb(0, `HPP_OFF_LIMIT0 + {7'h00, p, 2'h0}, 0);
            `CHK(rd, {20'h0, lim})
            smp(p, c, 0, 13'h0100);
            apb(0, `HPP_OFF_OC_FLAG, 0);
            `CHK(rd[p], t)
            `CHK(o_port_power[p], !t)
            apb(1, `HPP_OFF_PORT_EN, 32'h0000_00FF & ~(32'h1 << p));
            apb(1, `HPP_OFF_PORT_EN, 32'h0000_00FF);
            apb(0, `HPP_OFF_OC_FLAG, 0);
            `CHK({rd[p], o_port_power[p]}, 2'b01)
        end
        apb(1, `HPP_OFF_LIMIT0 + 12'h010, 32'h0000_0010);
        smp(4, 12'h020, 0, 13'h0100);
        smp(4, 12'h001, 0, 13'h0100);
        apb(0, `HPP_OFF_OC_FLAG, 0);
        `CHK({rd[4], o_port_power[4]}, 2'b10)
        apb(1, `HPP_OFF_OC_FLAG, 32'h0000_0010);
        apb(0, `HPP_OFF_OC_FLAG, 0);
        `CHK(rd[4], 1'b0)
        smp(5, 0, 1, 13'h0100);
        smp(5, 0, 0, 13'h0A8D);
        smp(5, 0, 0, 13'h0A8C);
        `CHK(o_port_power[5], 1'b1)
        for (i = 0; i < 3; i = i + 1) begin
            smp(5, 0, i[0] == 0, i[0] ? 13'h0A8D : 13'h0100);
        end
        apb(0, `HPP_OFF_FLT_STAT, 0);
        `CHK({rd[5], o_port_power[5]}, 2'b10)
        smp(5, 0, 0, 13'h0A8C);
        `CHK(o_port_power[5], 1'b0)
        repeat (60) @(posedge i_clk);
        smp(5, 0, 0, 13'h0A8C);
        `CHK(o_port_power[5], 1'b1)
        `CHK({o_up_select, o_up0_route_en}, 2'b01)
        i_up0_connected <= 0;
        i_up1_connected <= 1;
        i_dn_enumerated <= 8'h03;
        i_dn_superspeed <= 8'h05;
        i_up_superspeed <= 1;
        repeat (8) @(posedge i_clk);
        `CHK({o_up_select, o_up1_route_en}, 2'b11)
        `CHK({o_led_dn_ss, o_led_dn_hs}, 16'h0102)
        `CHK({o_led_up_ss, o_led_up_hs}, 2'b10)
        i_up0_connected <= 1;
        apb(1, `HPP_OFF_CTRL, 32'h0000_0002);
        i_ctrl_attached <= 1;
        repeat (8) @(posedge i_clk);
        `CHK(o_up_select, 1'b1)
        `CHK({o_mgmt_via_ctrl, o_mgmt_via_up}, 2'b10)
        `CHK(o_ctrl_data_en, 1'b0)
        apb(1, `HPP_OFF_HB_DIV, 32'h0000_0004);
        apb(1, `HPP_OFF_CTRL, 32'h0000_0005);
        repeat (8) @(posedge i_clk);
        `CHK({o_led_link, o_up_select}, 2'b10)
        n = 0;
        for (i = 0; i < 40; i = i + 1) begin
            hb = o_led_heartbeat;
            @(posedge i_clk);
            n = n + (o_led_heartbeat !== hb);
        end
        `CHK(n inside {[7:11]}, 1'b1)
        apb(1, `HPP_OFF_CTRL, 32'h0000_000D);
        n = 0;
        for (i = 0; i < 40; i = i + 1) begin
            hb = o_led_health;
            @(posedge i_clk);
            n = n + (o_led_health !== hb);
        end
        `CHK(n inside {[7:11]}, 1'b1)
        print_verdict;
    end
endmodule
